/* sbl_loader.sv */
// serial bootstrap loader: sync, autobaud, download, echo, exit jump
// Operation
// - four idle character times end the download
// - idle timeout armed only after sync character
// - wait for sync forever after reset
// - sync picks fast or 1200 baud
// - download zero to 512 bytes into RAM
// - first byte zero jumps to EEPROM start
// - echo every received download byte
// - transmitter double buffered, two-character pipeline
// - reset low, mode pins low: EPROM emulation
// - emulated output enable steers data port direction
// - boot ROM map bit: set in bootstrap, protected otherwise
// - mapped boot ROM overrides user ROM reads
// - programming pulse lasts 2 ms
// - idle timeout jumps to RAM start
// - break as first character jumps to EEPROM
// assumes all inputs synchronous to the 40 MHz clk_i
`timescale 1ns/1ps
`include "sbl_defs.svh"

module sbl_loader
  import sbl_pkg::*;
#(
  parameter sbl_cyc_t    FAST_BIT_CYC =
    20'(`SBL_CLK_HZ * 2 / `SBL_FAST_BAUD_X2),
  parameter sbl_cyc_t    SLOW_BIT_CYC = 20'(`SBL_CLK_HZ / `SBL_SLOW_BAUD),
  parameter logic [16:0] PROG_CYC     =
    17'(`SBL_CLK_HZ / `SBL_US_PER_S * `SBL_PROG_PULSE_US)
)
(
  input  wire logic        clk_i,           // system clock
  input  wire logic        rst_n_i,         // async reset, active low
  input  wire logic        mode_a_i,        // mode select pin a
  input  wire logic        mode_b_i,        // mode select pin b
  input  wire logic        rxd_i,           // serial receive line
  output logic             txd_o,           // serial transmit line
  output logic             jump_valid_o,    // loader finished
  output logic [15:0]      jump_addr_o,     // where to start running
  output logic [9:0]       load_len_o,      // bytes stored
  output logic             baud_slow_o,     // slow rate selected
  input  wire logic [8:0]  ram_rd_addr_i,   // loaded RAM read address
  output logic [7:0]       ram_rd_data_o,   // loaded RAM read data
  input  wire logic        map_wr_i,        // write boot rom map bit
  input  wire logic        map_wdata_i,     // value for map bit
  output logic             boot_rom_map_enable_o, // map bit
  input  wire logic [15:0] cpu_addr_i,      // cpu read address
  input  wire logic [7:0]  boot_rom_data_i, // boot ROM data
  input  wire logic [7:0]  user_rom_data_i, // user ROM/EPROM data
  output logic             boot_rom_sel_o,  // boot ROM decoded
  output logic [7:0]       cpu_rd_data_o,   // registered read data
  output logic             emulation_mode_o, // EPROM emulation active
  input  wire logic        emu_oe_n_i,      // emulated output enable
  input  wire logic [7:0]  emu_data_i,      // EPROM data to drive
  output logic [7:0]       port_data_o,     // data port output
  output logic             port_oe_n_o,     // data port drive, low
  input  wire logic        prog_start_i,    // start program pulse
  output logic             prog_pulse_o     // program voltage on
);

  localparam sbl_cyc_t FAST_LIM =
    20'(FAST_BIT_CYC * `SBL_FAST_LIMIT_MUL);
  localparam sbl_cyc_t BRK_LIM  = 20'(SLOW_BIT_CYC * `SBL_BREAK_BITS);

  sbl_state_e  state_reg;
  sbl_cyc_t    meas_reg;
  sbl_cyc_t    bit_cyc_reg;
  sbl_cyc_t    tail_lim;
  logic [21:0] idle_reg;
  logic [21:0] idle_lim;
  logic [9:0]  byte_cnt_reg;
  logic [7:0]  ram_mem [`SBL_RAM_BYTES];
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_wr;
  logic        first_zero;
  logic        store;
  logic        boot_mode_reg;
  logic        strap_done_reg;
  logic [16:0] prog_cnt_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // serial link
  sbl_uart u_uart (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .bit_cyc_i  (bit_cyc_reg),
    .rx_en_i    (state_reg == SBL_LOAD),
    .rxd_i      (rxd_i),
    .rx_valid_o (rx_valid),
    .rx_data_o  (rx_data),
    .tx_wr_i    (tx_wr),
    .tx_data_i  (rx_data),
    .tx_ready_o (),
    .txd_o      (txd_o)
  );

  // ==========================================================
  // sequencer
  assign tail_lim   = 20'(bit_cyc_reg * 20'(`SBL_SYNC_TAIL_BITS));
  assign idle_lim   = 22'(bit_cyc_reg) *
                      22'(`SBL_IDLE_CHARS * `SBL_BITS_PER_CHAR);
  assign first_zero = (byte_cnt_reg == 10'h0) && (rx_data == `SBL_ZERO_BYTE);
  assign store      = (state_reg == SBL_LOAD) && rx_valid && !first_zero;
  assign tx_wr      = store;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= SBL_SYNC_WAIT;
      meas_reg    <= '0;
      bit_cyc_reg <= FAST_BIT_CYC;
      jump_addr_o <= `SBL_RAM_START;
    end else begin
      unique case (state_reg)
        SBL_SYNC_WAIT: begin
          meas_reg <= '0;
          if (!rxd_i) begin
            state_reg <= SBL_SYNC_MEAS;
          end
        end
        SBL_SYNC_MEAS: begin
          meas_reg <= meas_reg + 20'h1;
          if (meas_reg >= BRK_LIM) begin
            state_reg   <= SBL_RUN_EEP;
            jump_addr_o <= `SBL_EEPROM_START;
          end else if (rxd_i) begin
            // a fast start bit is one fast bit; slow one is far longer
            bit_cyc_reg <= (meas_reg < FAST_LIM) ? FAST_BIT_CYC
                                                 : SLOW_BIT_CYC;
            meas_reg    <= '0;
            state_reg   <= SBL_SYNC_TAIL;
          end
        end
        SBL_SYNC_TAIL: begin
          // let the rest of the sync character pass before arming
          meas_reg <= meas_reg + 20'h1;
          if (meas_reg >= tail_lim) begin
            state_reg <= SBL_LOAD;
          end
        end
        SBL_LOAD: begin
          if (rx_valid && first_zero) begin
            state_reg   <= SBL_RUN_EEP;
            jump_addr_o <= `SBL_EEPROM_START;
          end else if (store && byte_cnt_reg == `SBL_RAM_LAST) begin
            state_reg   <= SBL_RUN_RAM;
            jump_addr_o <= `SBL_RAM_START;
          end else if (idle_reg >= idle_lim) begin
            state_reg   <= SBL_RUN_RAM;
            jump_addr_o <= `SBL_RAM_START;
          end
        end
        SBL_RUN_RAM, SBL_RUN_EEP: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // idle gap timer, cleared whenever the line shows activity
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_reg <= '0;
    end else if (state_reg != SBL_LOAD || !rxd_i || rx_valid) begin
      idle_reg <= '0;
    end else if (idle_reg < idle_lim) begin
      idle_reg <= idle_reg + 22'h1;
    end
  end

  // download store, limited to the RAM size
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_cnt_reg <= '0;
    end else if (store) begin
      byte_cnt_reg <= byte_cnt_reg + 10'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (store) begin
      ram_mem[byte_cnt_reg[8:0]] <= rx_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_rd_data_o <= '0;
    end else begin
      ram_rd_data_o <= ram_mem[ram_rd_addr_i];
    end
  end

  assign jump_valid_o = (state_reg == SBL_RUN_RAM) ||
                        (state_reg == SBL_RUN_EEP);
  assign load_len_o   = byte_cnt_reg;
  assign baud_slow_o  = (bit_cyc_reg == SLOW_BIT_CYC);

  // ==========================================================
  // boot ROM mapping; strap is caught on the first edge after release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done_reg        <= 1'b0;
      boot_mode_reg         <= 1'b0;
      boot_rom_map_enable_o <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg        <= 1'b1;
      boot_mode_reg         <= !mode_a_i && !mode_b_i;
      boot_rom_map_enable_o <= !mode_a_i && !mode_b_i;
    end else if (map_wr_i && boot_mode_reg) begin
      boot_rom_map_enable_o <= map_wdata_i;
    end
  end

  assign boot_rom_sel_o = boot_rom_map_enable_o &&
                          (cpu_addr_i[15:8] == `SBL_BOOTROM_PAGE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_rd_data_o <= '0;
    end else begin
      cpu_rd_data_o <= boot_rom_sel_o ? boot_rom_data_i
                                      : user_rom_data_i;
    end
  end

  // ==========================================================
  // EPROM emulation pins follow the reset and mode pins directly
  assign emulation_mode_o = !rst_n_i && !mode_a_i && !mode_b_i;
  assign port_oe_n_o      = !(emulation_mode_o && !emu_oe_n_i);
  assign port_data_o      = emu_data_i;

  // ==========================================================
  // programming pulse timer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_cnt_reg <= '0;
      prog_pulse_o <= 1'b0;
    end else if (!prog_pulse_o && prog_start_i) begin
      prog_cnt_reg <= PROG_CYC - 17'h1;
      prog_pulse_o <= 1'b1;
    end else if (prog_pulse_o) begin
      if (prog_cnt_reg == '0) begin
        prog_pulse_o <= 1'b0;
      end else begin
        prog_cnt_reg <= prog_cnt_reg - 17'h1;
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_line_idle_long;
    (state_reg == SBL_LOAD) && (idle_reg >= idle_lim) && !rx_valid;
  endsequence

  sequence s_break_held;
    (state_reg == SBL_SYNC_MEAS) && (meas_reg >= BRK_LIM);
  endsequence

  a_idle_ends_load: assert property (
    s_line_idle_long |=> (state_reg == SBL_RUN_RAM) &&
                         (jump_addr_o == `SBL_RAM_START))
    else $error("idle gap did not end the download");

  a_idle_not_armed: assert property (
    (state_reg != SBL_LOAD) |=> (idle_reg == '0) || (state_reg == SBL_LOAD))
    else $error("idle timer ran before sync");

  a_sync_waits: assert property (
    (state_reg == SBL_SYNC_WAIT && rxd_i) |=> (state_reg == SBL_SYNC_WAIT))
    else $error("loader left sync wait without a start bit");

  a_baud_pick: assert property (
    (state_reg == SBL_SYNC_MEAS && rxd_i && meas_reg < BRK_LIM) |=>
    (bit_cyc_reg == (($past(meas_reg) < FAST_LIM) ? FAST_BIT_CYC
                                                  : SLOW_BIT_CYC)))
    else $error("wrong baud rate selected from sync");

  a_count_bounded: assert property (
    byte_cnt_reg <= `SBL_RAM_FULL)
    else $error("download stored past the RAM size");

  a_zero_to_eeprom: assert property (
    (state_reg == SBL_LOAD && rx_valid && first_zero) |=>
    (state_reg == SBL_RUN_EEP) && (jump_addr_o == `SBL_EEPROM_START) &&
    (byte_cnt_reg == 10'h0))
    else $error("zero first byte did not jump to EEPROM");

  a_echo_each: assert property (
    (state_reg == SBL_LOAD && rx_valid && !first_zero) |-> tx_wr)
    else $error("received byte not echoed");

  a_break_eeprom: assert property (
    s_break_held |=> (state_reg == SBL_RUN_EEP))
    else $error("break did not jump to EEPROM");

  a_full_to_ram: assert property (
    (store && byte_cnt_reg == `SBL_RAM_LAST) |=>
    (state_reg == SBL_RUN_RAM) && (byte_cnt_reg == `SBL_RAM_FULL))
    else $error("full RAM did not jump to RAM");

  a_map_protect: assert property (
    (strap_done_reg && !boot_mode_reg) |-> !boot_rom_map_enable_o)
    else $error("map bit set outside bootstrap mode");

  a_rom_override: assert property (
    boot_rom_sel_o |=> (cpu_rd_data_o == $past(boot_rom_data_i)))
    else $error("mapped boot ROM not returned");

  a_prog_start: assert property (
    (prog_start_i && !prog_pulse_o) |=>
    prog_pulse_o && (prog_cnt_reg == PROG_CYC - 17'h1))
    else $error("program pulse did not start with full count");

endmodule

/* sbl_defs.svh */
// timing, address and count constants of the serial bootstrap loader
// assumes a 40 MHz clock; included by bare name from the loader and uart design files
`ifndef SBL_DEFS_SVH
`define SBL_DEFS_SVH

`define SBL_CLK_HZ         40000000
`define SBL_FAST_BAUD_X2   15625
`define SBL_SLOW_BAUD      1200
`define SBL_PROG_PULSE_US  2000
`define SBL_US_PER_S       1000000
`define SBL_IDLE_CHARS     4
`define SBL_BITS_PER_CHAR  10
`define SBL_FAST_LIMIT_MUL 2
`define SBL_BREAK_BITS     10
`define SBL_SYNC_TAIL_BITS 9
`define SBL_STOP_BIT       4'h9
`define SBL_RAM_BYTES      512
`define SBL_RAM_LAST       10'h1ff
`define SBL_RAM_FULL       10'h200
`define SBL_ZERO_BYTE      8'h00
`define SBL_EEPROM_START   16'hb600
`define SBL_RAM_START      16'h0000
`define SBL_BOOTROM_PAGE   8'hbf

`endif

/* sbl_pkg.sv */
// types shared by the serial bootstrap loader files
// assumes nothing of its surroundings
package sbl_pkg;

  // gray codes along wait, measure, tail, load, run ram
  typedef enum logic [2:0] {
    SBL_SYNC_WAIT = 3'h0,
    SBL_SYNC_MEAS = 3'h1,
    SBL_SYNC_TAIL = 3'h3,
    SBL_LOAD      = 3'h2,
    SBL_RUN_RAM   = 3'h6,
    SBL_RUN_EEP   = 3'h7
  } sbl_state_e;

  typedef logic [19:0] sbl_cyc_t;

endpackage

/* sbl_uart.sv */
// async serial interface: 8N1 receiver and double-buffered transmitter
// assumes rxd_i synchronous to clk_i; bit period given in clock cycles
`timescale 1ns/1ps
`include "sbl_defs.svh"

module sbl_uart
  import sbl_pkg::*;
(
  input  wire logic       clk_i,      // system clock
  input  wire logic       rst_n_i,    // async reset, active low
  input  wire sbl_cyc_t   bit_cyc_i,  // cycles per bit
  input  wire logic       rx_en_i,    // receiver armed
  input  wire logic       rxd_i,      // serial receive line
  output logic            rx_valid_o, // one-cycle byte strobe
  output logic [7:0]      rx_data_o,  // received byte
  input  wire logic       tx_wr_i,    // write transmit holding reg
  input  wire logic [7:0] tx_data_i,  // byte to send
  output logic            tx_ready_o, // holding register empty
  output logic            txd_o       // serial transmit line
);

  logic       rx_act_reg;
  sbl_cyc_t   rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic       rx_prev_reg;
  logic       hold_full_reg;
  logic [7:0] hold_reg;
  logic       tx_act_reg;
  logic [9:0] tx_sh_reg;
  sbl_cyc_t   tx_cnt_reg;
  logic [3:0] tx_bit_reg;

  // ==========================================================
  // receiver
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_act_reg  <= 1'b0;
      rx_cnt_reg  <= '0;
      rx_bit_reg  <= '0;
      rx_sh_reg   <= '0;
      rx_prev_reg <= 1'b1;
      rx_valid_o  <= 1'b0;
      rx_data_o   <= '0;
    end else begin
      rx_prev_reg <= rxd_i;
      rx_valid_o  <= 1'b0;
      if (!rx_act_reg) begin
        if (rx_en_i && rx_prev_reg && !rxd_i) begin
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= bit_cyc_i >> 1;
          rx_bit_reg <= '0;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 20'h1;
      end else begin
        rx_cnt_reg <= bit_cyc_i - 20'h1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rxd_i) begin
          rx_act_reg <= 1'b0; // glitch, not a start bit
        end else if (rx_bit_reg == `SBL_STOP_BIT) begin
          rx_act_reg <= 1'b0;
          if (rxd_i) begin
            rx_valid_o <= 1'b1;
            rx_data_o  <= rx_sh_reg;
          end
        end else if (rx_bit_reg != 4'h0) begin
          rx_sh_reg <= {rxd_i, rx_sh_reg[7:1]};
        end
      end
    end
  end

  // ==========================================================
  // transmitter: holding register feeds the shifter
  assign tx_ready_o = !hold_full_reg;
  assign txd_o      = tx_sh_reg[0];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_full_reg <= 1'b0;
      hold_reg      <= '0;
      tx_act_reg    <= 1'b0;
      tx_sh_reg     <= '1;
      tx_cnt_reg    <= '0;
      tx_bit_reg    <= '0;
    end else begin
      if (tx_wr_i && !hold_full_reg) begin
        hold_full_reg <= 1'b1;
        hold_reg      <= tx_data_i;
      end
      if (!tx_act_reg) begin
        if (hold_full_reg) begin
          tx_sh_reg     <= {1'b1, hold_reg, 1'b0};
          tx_act_reg    <= 1'b1;
          tx_cnt_reg    <= bit_cyc_i - 20'h1;
          tx_bit_reg    <= '0;
          hold_full_reg <= 1'b0;
        end
      end else if (tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - 20'h1;
      end else begin
        tx_cnt_reg <= bit_cyc_i - 20'h1;
        tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
        if (tx_bit_reg == `SBL_STOP_BIT) begin
          tx_act_reg <= 1'b0;
        end else begin
          tx_bit_reg <= tx_bit_reg + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // checks
  a_tx_double_buffer: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (tx_wr_i && tx_ready_o && tx_act_reg) |=>
    (hold_full_reg && (hold_reg == $past(tx_data_i))))
    else $error("byte written during shift was not held");

  a_rx_stop_high: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rx_valid_o |-> $past(rxd_i) && !rx_act_reg)
    else $error("byte delivered without a high stop bit");

endmodule

/* sbl_host_model.sv */
// host model: sends 8N1 characters and collects echoed bytes
// assumes its line ports are wired to the loader serial pins
`timescale 1ns/1ps

module sbl_host_model (
  input  wire logic clk_i, // system clock
  input  wire logic rxd_i, // echo from loader
  output logic      txd_o  // line into loader
);
  int         bit_cyc;
  logic [7:0] echo_q[$];
  logic [7:0] sh;

  initial begin
    txd_o = 1'b1;
    bit_cyc = 16;
  end

  // ==========================================
  // sender, called at a falling edge
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic send_byte(input logic [7:0] b);
    txd_o = 1'b0;
    wait_cyc(bit_cyc);
    for (int i = 0; i < 8; i++) begin
      txd_o = b[i];
      wait_cyc(bit_cyc);
    end
    txd_o = 1'b1;
    // two idle bits between characters, far below the idle limit
    wait_cyc(2 * bit_cyc);
  endtask

  task automatic send_break(input int n);
    txd_o = 1'b0;
    wait_cyc(n);
    txd_o = 1'b1;
    wait_cyc(bit_cyc);
  endtask

  // ==========================================
  // echo receiver, samples mid-bit
  always begin
    @(negedge rxd_i);
    repeat (bit_cyc / 2) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(negedge clk_i);
      sh[i] = rxd_i;
    end
    repeat (bit_cyc) @(negedge clk_i);
    if (rxd_i === 1'b1) begin
      echo_q.push_back(sh);
    end
  end
endmodule

/* sbl_loader_bench.sv */
// testbench for the serial bootstrap loader
// assumes sbl_loader and sbl_host_model; shortened bit periods
`timescale 1ns/1ps

module sbl_loader_bench;
  import sbl_pkg::*;
  localparam sbl_cyc_t    FB = 20'h8;
  localparam sbl_cyc_t    SB = 20'h80;
  localparam logic [16:0] PC = 17'h14;

  logic        clk_i, rst_n_i, mode_a_i, mode_b_i;
  wire logic   rxd_i;
  logic        txd_o, jump_valid_o, baud_slow_o;
  logic [15:0] jump_addr_o, cpu_addr_i;
  logic [9:0]  load_len_o;
  logic [8:0]  ram_rd_addr_i;
  logic [7:0]  ram_rd_data_o, boot_rom_data_i, user_rom_data_i;
  logic [7:0]  cpu_rd_data_o, emu_data_i, port_data_o;
  logic        map_wr_i, map_wdata_i, boot_rom_map_enable_o;
  logic        boot_rom_sel_o, emulation_mode_o, emu_oe_n_i;
  logic        port_oe_n_o, prog_start_i, prog_pulse_o;
  int          n_errors, comparisons;

  sbl_loader #(.FAST_BIT_CYC(FB), .SLOW_BIT_CYC(SB), .PROG_CYC(PC))
    sbl_loader_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_a_i(mode_a_i),
    .mode_b_i(mode_b_i), .rxd_i(rxd_i), .txd_o(txd_o),
    .jump_valid_o(jump_valid_o), .jump_addr_o(jump_addr_o),
    .load_len_o(load_len_o), .baud_slow_o(baud_slow_o),
    .ram_rd_addr_i(ram_rd_addr_i), .ram_rd_data_o(ram_rd_data_o),
    .map_wr_i(map_wr_i), .map_wdata_i(map_wdata_i),
    .boot_rom_map_enable_o(boot_rom_map_enable_o),
    .cpu_addr_i(cpu_addr_i), .boot_rom_data_i(boot_rom_data_i),
    .user_rom_data_i(user_rom_data_i), .boot_rom_sel_o(boot_rom_sel_o),
    .cpu_rd_data_o(cpu_rd_data_o), .emulation_mode_o(emulation_mode_o),
    .emu_oe_n_i(emu_oe_n_i), .emu_data_i(emu_data_i),
    .port_data_o(port_data_o), .port_oe_n_o(port_oe_n_o),
    .prog_start_i(prog_start_i), .prog_pulse_o(prog_pulse_o));

  sbl_host_model sbl_host_model_i (
    .clk_i(clk_i), .rxd_i(txd_o), .txd_o(rxd_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ==========================================
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_jump(input int lim);
    int n;
    n = 0;
    while (jump_valid_o !== 1'b1 && n < lim) begin
      n++;
      @(negedge clk_i);
    end
    if (jump_valid_o !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t loader never finished", $time);
      give_verdict();
    end
  endtask

  task automatic do_reset(input logic a, input logic b);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    mode_a_i = a;
    mode_b_i = b;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    sbl_host_model_i.echo_q.delete();
    @(negedge clk_i);
  endtask

  // ==========================================
  // scenarios
  task automatic t_download();
    do_reset(1'b0, 1'b0);
    sbl_host_model_i.bit_cyc = FB;
    // a long quiet spell before sync must not end anything
    repeat (200 * FB) @(negedge clk_i);
    check(16'(jump_valid_o), 16'h0);
    sbl_host_model_i.send_byte(8'hff);
    check(16'(baud_slow_o), 16'h0);
    sbl_host_model_i.send_byte(8'h5a);
    sbl_host_model_i.send_byte(8'ha5);
    repeat (30 * FB) @(negedge clk_i);
    check(16'(jump_valid_o), 16'h0);
    check(16'(jump_valid_o), 16'h0);
    wait_jump(20 * FB);
    check(jump_addr_o, 16'h0000);
    check(16'(load_len_o), 16'h2);
    check(16'(sbl_host_model_i.echo_q.size()), 16'h2);
    if (sbl_host_model_i.echo_q.size() == 2) begin
      check(16'(sbl_host_model_i.echo_q[0]), 16'h5a);
      check(16'(sbl_host_model_i.echo_q[1]), 16'ha5);
    end
    ram_rd_addr_i = 9'h000;
    @(negedge clk_i);
    check(16'(ram_rd_data_o), 16'h5a);
    ram_rd_addr_i = 9'h001;
    @(negedge clk_i);
    check(16'(ram_rd_data_o), 16'ha5);
  endtask

  task automatic t_full();
    do_reset(1'b0, 1'b0);
    sbl_host_model_i.bit_cyc = FB;
    sbl_host_model_i.send_byte(8'hff);
    for (int i = 0; i < 512; i++) begin
      sbl_host_model_i.send_byte(8'(i) ^ 8'h5a);
    end
    check(16'(jump_valid_o), 16'h1);
    check(jump_addr_o, 16'h0000);
    check(16'(load_len_o), 16'h200);
    ram_rd_addr_i = 9'h1ff;
    repeat (20 * FB) @(negedge clk_i);
    check(16'(ram_rd_data_o), 16'ha5);
    check(16'(sbl_host_model_i.echo_q.size()), 16'h200);
  endtask

  task automatic t_slow_zero();
    do_reset(1'b0, 1'b0);
    sbl_host_model_i.bit_cyc = SB;
    sbl_host_model_i.send_byte(8'hff);
    check(16'(baud_slow_o), 16'h1);
    sbl_host_model_i.send_byte(8'h00);
    wait_jump(4 * SB);
    check(jump_addr_o, 16'hb600);
    check(16'(load_len_o), 16'h0);
    repeat (12 * SB) @(negedge clk_i);
    check(16'(sbl_host_model_i.echo_q.size()), 16'h0);
  endtask

  task automatic t_break();
    do_reset(1'b0, 1'b0);
    sbl_host_model_i.bit_cyc = FB;
    sbl_host_model_i.send_break(10 * SB + 4);
    wait_jump(4 * FB);
    check(jump_addr_o, 16'hb600);
    check(16'(load_len_o), 16'h0);
  endtask

  task automatic t_map_emu();
    int n;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    mode_a_i = 1'b0;
    mode_b_i = 1'b0;
    emu_oe_n_i = 1'b0;
    emu_data_i = 8'h3c;
    #1 check(16'(emulation_mode_o), 16'h1);
    check(16'(port_oe_n_o), 16'h0);
    check(16'(port_data_o), 16'h3c);
    emu_oe_n_i = 1'b1;
    #1 check(16'(port_oe_n_o), 16'h1);
    mode_a_i = 1'b1;
    #1 check(16'(emulation_mode_o), 16'h0);
    do_reset(1'b0, 1'b0);
    check(16'(boot_rom_map_enable_o), 16'h1);
    cpu_addr_i = 16'hbf10;
    @(negedge clk_i);
    check(16'(boot_rom_sel_o), 16'h1);
    check(16'(cpu_rd_data_o), 16'hc3);
    map_wr_i = 1'b1;
    map_wdata_i = 1'b0;
    @(negedge clk_i);
    map_wr_i = 1'b0;
    check(16'(boot_rom_map_enable_o), 16'h0);
    @(negedge clk_i);
    check(16'(cpu_rd_data_o), 16'h77);
    do_reset(1'b1, 1'b0);
    map_wr_i = 1'b1;
    map_wdata_i = 1'b1;
    @(negedge clk_i);
    map_wr_i = 1'b0;
    check(16'(boot_rom_map_enable_o), 16'h0);
    prog_start_i = 1'b1;
    @(negedge clk_i);
    prog_start_i = 1'b0;
    n = 0;
    while (prog_pulse_o === 1'b1 && n < 100) begin
      n++;
      @(negedge clk_i);
    end
    check(16'(n), 16'(PC));
  endtask

  // ==========================================
  // main sequence
  initial begin
    n_errors = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    mode_a_i = 1'b0;
    mode_b_i = 1'b0;
    ram_rd_addr_i = 9'h000;
    map_wr_i = 1'b0;
    map_wdata_i = 1'b0;
    cpu_addr_i = 16'h0000;
    boot_rom_data_i = 8'hc3;
    user_rom_data_i = 8'h77;
    emu_oe_n_i = 1'b1;
    emu_data_i = 8'h00;
    prog_start_i = 1'b0;
    t_download();
    t_full();
    t_slow_zero();
    t_break();
    t_map_emu();
    give_verdict();
  end
endmodule
